// *** sar_adc_pkg_buf.sv ***
// Shared constants and types of the converter control, and its two-entry result buffer.
package sar_adc_pkg;
  // ==========================================================================
  // Timing.
  localparam int MCLK_MHZ = 40;
  localparam int RST_MIN_NS = 1;
  localparam int RST_MAX_NS = 100;
  localparam int TSENSE_US = 100;
  localparam int RST_MIN_CYC_RAW = (RST_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int RST_MIN_CYC = (RST_MIN_CYC_RAW < 1) ? 1 : RST_MIN_CYC_RAW;
  localparam int RST_MAX_CYC = (RST_MAX_NS * MCLK_MHZ) / 1000;
  localparam int TSENSE_CYC = TSENSE_US * MCLK_MHZ;
  localparam int LOW_CNT_W = 8;
  localparam int TS_CNT_W = 12;
  // ==========================================================================
  // Serial word and control word layout.
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int CHAN_W = 4;
  localparam int NUM_CHAN = 8;
  localparam int CTRL_WRITE_BIT = 15;
  localparam int CTRL_CH_HI = 14;
  localparam int CTRL_CH_LO = 7;
  localparam int CTRL_TSENSE_BIT = 6;
  localparam int CTRL_PPD_BIT = 5;
  localparam logic [7:0] CH_EN_RESET = 8'h01;
  localparam logic [3:0] TSENSE_CHAN = 4'h8;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [CODE_W-1:0] code;
  } result_t;

  typedef struct packed {
    logic [7:0] ch_en;
    logic tsense;
    logic partial_power_down_bit;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{ch_en: CH_EN_RESET, tsense: 1'b0, partial_power_down_bit: 1'b0};
endpackage

`timescale 1ns/100ps
module result_buffer
  import sar_adc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire result_t in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output result_t out_data
);
  result_t slot [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot[rd_ptr];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else begin
      if (push) begin
        slot[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// *** sar_adc_ctrl.sv ***
// Control logic of the eight-channel successive-approximation converter.
`timescale 1ns/100ps
module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Serial pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  // Power pin and power state.
  input wire logic power_down_reset_pin_n,
  output logic full_power_down,
  output logic partial_power_down,
  // Analog front end.
  input wire logic comp_high,
  output logic sample_hold,
  output logic [CODE_W-1:0] dac_code,
  output logic [CHAN_W-1:0] mux_chan,
  output logic tsense_busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  function automatic logic [2:0] next_channel(input logic [2:0] cur, input logic [7:0] en);
    logic [2:0] res;
    logic [2:0] idx;
    res = cur;
    for (int i = 7; i >= 1; i--) begin
      idx = cur + 3'(i);
      if (en[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Pin synchronisers and edge detection.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [1:0] sync3;
  wire cs_s = sync2[0];
  wire sclk_s = sync2[1];
  wire din_s = sync2[2];
  wire pd_s = sync2[3];
  wire comp_s = sync2[4];
  wire cs_fall = !cs_s && sync3[0];
  wire cs_rise = cs_s && !sync3[0];
  wire sclk_rise = sclk_s && !sync3[1];
  wire sclk_fall = !sclk_s && sync3[1];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      sync3 <= 2'h3;
    end else begin
      sync1 <= {comp_high, power_down_reset_pin_n, din, sclk, cs_n};
      sync2 <= sync1;
      sync3 <= sync2[1:0];
    end
  end

  // ==========================================================================
  // Power-down pin pulse discrimination.
  logic [LOW_CNT_W-1:0] low_cnt;
  logic pd_prev;
  logic soft_reset;
  wire pd_rise = pd_s && !pd_prev;
  wire low_sat = (low_cnt > LOW_CNT_W'(RST_MAX_CYC));
  wire short_pulse = pd_rise && (low_cnt >= LOW_CNT_W'(RST_MIN_CYC)) && !low_sat;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= '0;
      pd_prev <= 1'b1;
      full_power_down <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      pd_prev <= pd_s;
      low_cnt <= pd_s ? '0 : (low_sat ? low_cnt : low_cnt + 1'b1);
      full_power_down <= !pd_s && (low_cnt >= LOW_CNT_W'(RST_MAX_CYC));
      soft_reset <= short_pulse;
    end
  end
  property p_pd_enter;
    (!pd_s && low_cnt == LOW_CNT_W'(RST_MAX_CYC)) |=> full_power_down;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

  // ==========================================================================
  // Control word capture, taken on falling serial clock edges.
  ctrl_t ctrl;
  logic [WORD_W-1:0] in_sh;
  logic [4:0] in_cnt;
  wire in_take = !cs_s && sclk_fall && (in_cnt != 5'(WORD_W));
  wire ctrl_load = cs_rise && (in_cnt == 5'(WORD_W)) && in_sh[CTRL_WRITE_BIT];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_sh <= '0;
      in_cnt <= '0;
      ctrl <= CTRL_RESET;
      partial_power_down <= 1'b0;
    end else begin
      if (in_take) begin
        in_sh <= {in_sh[WORD_W-2:0], din_s};
      end
      in_cnt <= cs_s ? '0 : (in_take ? in_cnt + 1'b1 : in_cnt);
      if (soft_reset) begin
        ctrl <= CTRL_RESET;
      end else if (ctrl_load) begin
        ctrl <= '{ch_en: in_sh[CTRL_CH_HI:CTRL_CH_LO], tsense: in_sh[CTRL_TSENSE_BIT],
                  partial_power_down_bit: in_sh[CTRL_PPD_BIT]};
      end
      partial_power_down <= ctrl.partial_power_down_bit && !soft_reset;
    end
  end
  property p_short_reset;
    short_pulse |=> soft_reset ##1 (ctrl == CTRL_RESET && !full_power_down);
  endproperty
  a_short_reset: assert property (p_short_reset) else $error("short pulse did not reset");
  property p_ppd;
    (ctrl_load && !soft_reset) |=> ##1 partial_power_down == in_sh[CTRL_PPD_BIT];
  endproperty
  a_ppd: assert property (p_ppd) else $error("partial power-down not applied");

  // ==========================================================================
  // Successive approximation, stepped by rising serial clock edges.
  typedef enum logic [2:0] {
    S_TRACK = 3'b001,
    S_CONV = 3'b010,
    S_DONE = 3'b100
  } conv_state_t;
  conv_state_t state;
  logic [2:0] chan;
  logic [3:0] bit_idx;
  logic buf_in_ready;
  logic buf_out_valid;
  result_t buf_out;
  wire conv_start = cs_fall && !full_power_down && buf_in_ready && (state == S_TRACK);
  wire conv_step = (state == S_CONV) && sclk_rise;
  wire conv_abort = (state == S_CONV) && cs_rise;
  wire res_push = (state == S_DONE);
  wire [CODE_W-1:0] bit_mask = CODE_W'(1) << bit_idx;
  wire [CODE_W-1:0] decided = comp_s ? dac_code : (dac_code & ~bit_mask);
  wire [CODE_W-1:0] next_trial = (bit_idx == 4'd0) ? decided : (decided | (bit_mask >> 1));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= S_TRACK;
      chan <= 3'd0;
      bit_idx <= '0;
      dac_code <= '0;
      sample_hold <= 1'b0;
      mux_chan <= '0;
    end else if (soft_reset || full_power_down) begin
      state <= S_TRACK;
      sample_hold <= 1'b0;
      chan <= soft_reset ? 3'd0 : chan;
    end else begin
      unique case (state)
        S_TRACK: begin
          if (conv_start) begin
            state <= S_CONV;
            sample_hold <= 1'b1;
            bit_idx <= 4'(CODE_W - 1);
            dac_code <= CODE_W'(1) << (CODE_W - 1);
            mux_chan <= {1'b0, chan};
            chan <= next_channel(chan, ctrl.ch_en);
          end
        end
        S_CONV: begin
          if (conv_abort) begin
            state <= S_TRACK;
            sample_hold <= 1'b0;
          end else if (conv_step) begin
            dac_code <= next_trial;
            bit_idx <= bit_idx - 1'b1;
            if (bit_idx == 4'd0) begin
              state <= S_DONE;
            end
          end
        end
        S_DONE: begin
          state <= S_TRACK;
          sample_hold <= 1'b0;
        end
      endcase
    end
  end
  property p_pd_stops;
    full_power_down |=> (state == S_TRACK && !sample_hold);
  endproperty
  a_pd_stops: assert property (p_pd_stops) else $error("conversion runs in power-down");
  property p_seq;
    (conv_start && !soft_reset) |=> (chan == next_channel($past(chan), ctrl.ch_en))
      && (mux_chan == {1'b0, $past(chan)});
  endproperty
  a_seq: assert property (p_seq) else $error("channel sequence wrong");
  property p_step;
    (conv_step && !conv_abort && !full_power_down && !soft_reset)
      |=> bit_idx == $past(bit_idx) - 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("search did not step");
  property p_done_track;
    (res_push && !soft_reset && !full_power_down) |=> (!sample_hold && state == S_TRACK);
  endproperty
  a_done_track: assert property (p_done_track) else $error("no return to track");
  property p_abort;
    conv_abort |=> !res_push [*2];
  endproperty
  a_abort: assert property (p_abort) else $error("aborted result reported");

  result_buffer u_buf (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(res_push),
    .in_ready(buf_in_ready),
    .in_data('{chan: mux_chan, code: dac_code}),
    .out_valid(buf_out_valid),
    .out_ready(cs_fall),
    .out_data(buf_out)
  );

  // ==========================================================================
  // Output shifter: previous frame's result, MSB first on falling serial clock.
  logic [WORD_W-1:0] out_sh;
  wire [WORD_W-1:0] load_word = buf_out_valid ? buf_out : '0;
  wire [WORD_W-1:0] next_out_sh = cs_fall ? load_word :
                                  ((!cs_s && sclk_fall) ? {out_sh[WORD_W-2:0], 1'b0} : out_sh);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_sh <= '0;
      dout <= 1'b0;
      dout_oe_n <= 1'b1;
    end else begin
      out_sh <= next_out_sh;
      dout <= next_out_sh[WORD_W-1];
      dout_oe_n <= cs_s;
    end
  end
  property p_oe;
    cs_fall |=> !dout_oe_n && dout == $past(load_word[WORD_W-1]);
  endproperty
  a_oe: assert property (p_oe) else $error("output not enabled with first bit");
  property p_shift;
    (!cs_s && sclk_fall && !cs_fall) |=> dout == $past(out_sh[WORD_W-2]);
  endproperty
  a_shift: assert property (p_shift) else $error("output bit order wrong");

  // ==========================================================================
  // Temperature conversion busy window.
  logic [TS_CNT_W-1:0] ts_cnt;
  wire ts_start = cs_fall && ctrl.tsense && !tsense_busy && !full_power_down;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ts_cnt <= '0;
      tsense_busy <= 1'b0;
    end else if (ts_start) begin
      ts_cnt <= TS_CNT_W'(TSENSE_CYC - 1);
      tsense_busy <= 1'b1;
    end else if (tsense_busy) begin
      ts_cnt <= ts_cnt - 1'b1;
      tsense_busy <= (ts_cnt != '0);
    end
  end
  property p_tsense;
    ts_start |=> tsense_busy [*8];
  endproperty
  a_tsense: assert property (p_tsense) else $error("temperature busy not held");
endmodule

// *** host_spi_model.sv ***
// Host serial controller model that frames transfers on the converter's serial pins.
`timescale 1ns/100ps
module host_spi_model (
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  // Received word.
  output logic [15:0] rd_word,
  output logic rd_strobe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b1;
    rd_word = 16'h0000;
    rd_strobe = 1'b0;
  end

  // Runs one frame of nbits serial clocks; the serial clock idles high outside frames.
  task automatic frame(input logic [15:0] wr, input int nbits, input logic rep);
    logic [15:0] rd;
    rd = 16'h0000;
    @(negedge mclk);
    cs_n <= 1'b0;
    repeat (8) @(negedge mclk);
    for (int i = 0; i < nbits; i++) begin
      din <= wr[15-i];
      repeat (2) @(negedge mclk);
      rd[15-i] = dout;
      sclk <= 1'b0;
      repeat (4) @(negedge mclk);
      sclk <= 1'b1;
      repeat (2) @(negedge mclk);
    end
    repeat (2) @(negedge mclk);
    cs_n <= 1'b1;
    din <= ~din;
    if (rep) begin
      rd_word <= rd;
      rd_strobe <= 1'b1;
      @(negedge mclk);
      rd_strobe <= 1'b0;
    end
    repeat (10) @(negedge mclk);
  endtask
endmodule

// *** sar_adc_conversion_control_bench.sv ***
// Self-checking bench of the converter control with a host model and a comparator model.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module sar_adc_conversion_control_bench import sar_adc_pkg::*;;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic pwr_pin_n = 1'b1;
  logic [CODE_W-1:0] vin = 12'h000;
  logic [CODE_W-1:0] dac_code;
  logic [CHAN_W-1:0] mux_chan;
  logic cs_n, sclk, din, dout, dout_oe_n, full_power_down, partial_power_down;
  logic sample_hold, tsense_busy, rd_strobe, comp_high;
  logic [15:0] rd_word, last, e;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h1cef_1387;
  int nfr = 0;
  int n;

  // The comparator keeps a trial bit while the held input is at or above the trial code.
  assign comp_high = (vin >= dac_code);

  sar_adc_ctrl sar_adc_ctrl_inst (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .power_down_reset_pin_n(pwr_pin_n),
    .full_power_down(full_power_down), .partial_power_down(partial_power_down),
    .comp_high(comp_high), .sample_hold(sample_hold), .dac_code(dac_code),
    .mux_chan(mux_chan), .tsense_busy(tsense_busy));

  host_spi_model host_spi_model_inst (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .rd_word(rd_word), .rd_strobe(rd_strobe));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_sim();
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Result monitor: each received word is compared with the oldest note.
  always @(posedge mclk) begin
    if (rd_strobe === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      `CHK("word", e, rd_word)
    end
  end

  // ==========================================================================
  // One full frame; the word read back is the previous conversion's.
  task automatic frame(input logic [15:0] wr, input logic [3:0] ch, input logic rep);
    vin = (nfr == 0) ? 12'h000 : (nfr == 1) ? 12'hfff : 12'($random(seed));
    nfr++;
    if (rep) exp_q.push_back(last);
    fork
      host_spi_model_inst.frame(wr, 16, rep);
      begin
        repeat (20) @(negedge mclk);
        `CHK("hold", 1'b1, sample_hold)
        `CHK("oe_n", 1'b0, dout_oe_n)
        `CHK("chan", ch, mux_chan)
      end
    join
    `CHK("track", 1'b0, sample_hold)
    `CHK("code", vin, dac_code)
    `CHK("oe_idle", 1'b1, dout_oe_n)
    last = {ch, vin};
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (12) @(negedge mclk);
    resetn <= 1'b1;
    repeat (4) @(negedge mclk);
    `CHK("fpd_rst", 1'b0, full_power_down)
    `CHK("ppd_rst", 1'b0, partial_power_down)
    last = 16'h0000;
    frame(16'h83a0, 4'h0, 1'b1);
    `CHK("ppd_set", 1'b1, partial_power_down)
    for (int k = 1; k < 5; k++) frame(16'h0000, 4'((k - 1) % 3), 1'b1);
    host_spi_model_inst.frame(16'h0000, 6, 1'b0);
    last = 16'h0000;
    // The cut frame still used channel 1, so the sequence goes on at channel 2.
    frame(16'h0000, 4'h2, 1'b1);
    frame(16'h0000, 4'h0, 1'b1);
    pwr_pin_n <= 1'b0;
    repeat (2) @(negedge mclk);
    pwr_pin_n <= 1'b1;
    repeat (6) @(negedge mclk);
    `CHK("ppd_soft", 1'b0, partial_power_down)
    `CHK("fpd_soft", 1'b0, full_power_down)
    frame(16'h80a0, 4'h0, 1'b0);
    pwr_pin_n <= 1'b0;
    repeat (8) @(negedge mclk);
    `CHK("fpd_on", 1'b1, full_power_down)
    host_spi_model_inst.frame(16'h0000, 16, 1'b0);
    pwr_pin_n <= 1'b1;
    repeat (5) @(negedge mclk);
    `CHK("fpd_off", 1'b0, full_power_down)
    `CHK("ppd_kept", 1'b1, partial_power_down)
    last = 16'h0000;
    frame(16'h0000, 4'h0, 1'b1);
    frame(16'h80c0, 4'h0, 1'b0);
    fork
      host_spi_model_inst.frame(16'h0000, 16, 1'b0);
      begin
        n = 0;
        while (tsense_busy !== 1'b1 && n < 20) begin
          @(negedge mclk);
          n++;
        end
        `CHK("busy_on", 1'b1, tsense_busy)
        while (tsense_busy === 1'b1 && n < 5000) begin
          @(negedge mclk);
          n++;
        end
        `CHK("busy_len", 1'b1, (n > 3990 && n < 4015))
      end
    join
    `CHK("queue_empty", 0, exp_q.size())
    end_sim();
  end

  initial begin
    #2000000;
    `CHK("timeout", 1'b0, 1'b1)
    end_sim();
  end
endmodule
